/* File: hdl/csts_top.sv */
// Purpose: Charge safety timer, temperature window and status pins
// Assumes: Comparator outputs arrive as asynchronous pin levels
// Notes: Oscillator period is a tick from a clock divider
//
// What this block does
// - Charge window lasts two to the twenty-two oscillator periods.
// - Window expiry without end-of-charge raises a timeout fault.
// - Timeout fault latches, charger stops, fault shown until released.
// - Only power cycling or an enable toggle releases the latched fault.
// - Precharge not exited within one eighth of the window faults and latches.
// - Temperature outside the window stops charging and shows a fault.
// - Temperature back inside the window starts a new cycle.
// - Cold flag sets above 1.4V, clears only below 1.2V.
// - Hot flag sets below 0.35V, clears only above 0.4V.
// - Status and fault pins are open-drain; released reads high.
// - Standby both high; charging status low; fault fault low.
// - Enable high allows charging; low stops it in low power.
// - Enable low clears the latched timer fault and timer count; rising clears the count.
// - New cycle on reset, recharge, temperature recovery, enable.
// - After completion, battery below recharge threshold restarts charging.
// - End-of-charge current changes status, charging runs to window end.
// - After reset the timer is clear and charging starts.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "csts_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module csts_top #(
   parameter int unsigned OSC_DIV = `CSTS_OSC_CYCLES,
   parameter int TMR_W = `CSTS_TMR_BITS,
   parameter int PRE_SHIFT = `CSTS_PRE_SHIFT
) (
   input wire logic i_ref_clk, // 20 MHz clock
   input wire logic i_rstn, // Power-on reset, active low
   input wire logic i_awvalid, // AXI write address valid
   output logic o_awready, // AXI write address ready
   input wire csts_pkg::csts_addr_t i_awaddr, // AXI write address
   input wire logic i_wvalid, // AXI write data valid
   output logic o_wready, // AXI write data ready
   input wire logic [31:0] i_wdata, // AXI write data
   input wire logic [3:0] i_wstrb, // AXI byte strobes
   output logic o_bvalid, // AXI write response valid
   input wire logic i_bready, // AXI write response ready
   output logic [1:0] o_bresp, // AXI write response
   input wire logic i_arvalid, // AXI read address valid
   output logic o_arready, // AXI read address ready
   input wire csts_pkg::csts_addr_t i_araddr, // AXI read address
   output logic o_rvalid, // AXI read data valid
   input wire logic i_rready, // AXI read data ready
   output logic [31:0] o_rdata, // AXI read data
   output logic [1:0] o_rresp, // AXI read response
   input wire logic i_en_pin, // Charge enable pin
   input wire logic i_window_comparator_a_rise, // Sense above 1.4V
   input wire logic i_window_comparator_a_fall, // Sense below 1.2V
   input wire logic i_window_comparator_b_fall, // Sense below 0.35V
   input wire logic i_window_comparator_b_rise, // Sense above 0.4V
   input wire logic i_vbat_above_min, // Precharge exit reached
   input wire logic i_eoc_current, // Current below end-of-charge
   input wire logic i_below_recharge_threshold, // Battery below recharge level
   input wire logic i_status_pin, // Status pin level
   input wire logic i_fault_pin, // Fault pin level
   output logic o_status_o, // Status pin drive value
   output logic o_status_oe, // Status pin pull low
   output logic o_fault_o, // Fault pin drive value
   output logic o_fault_oe, // Fault pin pull low
   output logic o_chg_on, // Charger power path on
   output logic o_low_power, // Low-power state
   output logic o_irq // Interrupt, active high level
);
   import csts_pkg::*;

   localparam logic [TMR_W-1:0] PRE_LIM = TMR_W'(1) << (TMR_W - PRE_SHIFT);
   localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

   csts_reg_if reg_if ();
   logic [7:0] pin_s;
   logic en_pin_s;
   logic cmp_a_rise_s;
   logic cmp_a_fall_s;
   logic cmp_b_fall_s;
   logic cmp_b_rise_s;
   logic vbat_min_s;
   logic eoc_s;
   logic rch_s;
   logic [1:0] pin_rb_s;
   logic [31:0] div_q;
   logic tick;
   logic [TMR_W-1:0] cnt_q;
   csts_state_e state_q;
   csts_state_e state_d;
   logic ctrl_en_q;
   logic en;
   logic en_q;
   logic en_rise;
   logic cold_q;
   logic hot_q;
   logic temp_bad;
   logic eoc_seen_q;
   logic full_hit;
   logic pre_hit;
   logic new_cycle;
   logic status_oe_q;
   logic fault_oe_q;
   logic [3:0] int_stat_q;
   logic [3:0] int_mask_q;
   logic [3:0] int_ev;
   logic wr_lo;

   ////////////////////////////////////////////////////////////////////
   // Pin inputs and bus slave

   csts_sync #(.W(10)) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_rstn (i_rstn),
      .i_async ({i_fault_pin, i_status_pin, i_below_recharge_threshold,
                 i_eoc_current, i_vbat_above_min, i_window_comparator_b_rise,
                 i_window_comparator_b_fall, i_window_comparator_a_fall,
                 i_window_comparator_a_rise, i_en_pin}),
      .o_sync ({pin_rb_s, pin_s})
   );
   assign {rch_s, eoc_s, vbat_min_s, cmp_b_rise_s, cmp_b_fall_s, cmp_a_fall_s,
           cmp_a_rise_s, en_pin_s} = pin_s;

   csts_axil u_axil (
      .i_ref_clk (i_ref_clk),
      .i_rstn (i_rstn),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_awaddr (i_awaddr),
      .i_wvalid (i_wvalid),
      .o_wready (o_wready),
      .i_wdata (i_wdata),
      .i_wstrb (i_wstrb),
      .o_bvalid (o_bvalid),
      .i_bready (i_bready),
      .o_bresp (o_bresp),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .i_araddr (i_araddr),
      .o_rvalid (o_rvalid),
      .i_rready (i_rready),
      .o_rdata (o_rdata),
      .o_rresp (o_rresp),
      .reg_if (reg_if.bus)
   );

   ////////////////////////////////////////////////////////////////////
   // Oscillator period tick and period counter

   // Divider runs from reset on, like the oscillator after power-up
   assign tick = (div_q == OSC_DIV - 1);
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         div_q <= 32'h0;
      end
      else
      begin
         div_q <= tick ? 32'h0 : div_q + 32'h1;
      end
   end

   assign full_hit = tick && (cnt_q == '1);
   assign pre_hit = (cnt_q == PRE_LIM);
   assign new_cycle = (state_d == CSTS_PRE) && (state_q != CSTS_PRE);

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cnt_q <= '0;
      end
      else if (en_rise || new_cycle || state_q == CSTS_IDLE)
      begin
         cnt_q <= '0;
      end
      else if (tick && (state_q == CSTS_PRE || state_q == CSTS_FAST))
      begin
         cnt_q <= cnt_q + TMR_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Enable and temperature window flags

   assign en = en_pin_s && ctrl_en_q;
   assign en_rise = en && !en_q;
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         en_q <= 1'b0;
      end
      else
      begin
         en_q <= en;
      end
   end

   // Set inputs win so an edge crossing both thresholds still flags
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cold_q <= 1'b0;
         hot_q <= 1'b0;
      end
      else
      begin
         if (cmp_a_rise_s)
         begin
            cold_q <= 1'b1;
         end
         else if (cmp_a_fall_s)
         begin
            cold_q <= 1'b0;
         end
         if (cmp_b_fall_s)
         begin
            hot_q <= 1'b1;
         end
         else if (cmp_b_rise_s)
         begin
            hot_q <= 1'b0;
         end
      end
   end
   assign temp_bad = cold_q || hot_q;

   ////////////////////////////////////////////////////////////////////
   // Charge sequence

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         CSTS_IDLE: state_d = CSTS_PRE;
         CSTS_PRE:
         begin
            if (temp_bad)
               state_d = CSTS_TEMP;
            else if (pre_hit && !vbat_min_s)
               state_d = CSTS_TOUT;
            else if (vbat_min_s)
               state_d = CSTS_FAST;
         end
         CSTS_FAST:
         begin
            if (temp_bad)
               state_d = CSTS_TEMP;
            else if (full_hit)
               state_d = eoc_seen_q ? CSTS_DONE : CSTS_TOUT;
         end
         CSTS_DONE:
         begin
            if (temp_bad)
               state_d = CSTS_TEMP;
            else if (rch_s)
               state_d = CSTS_PRE;
         end
         CSTS_TEMP: if (!temp_bad) state_d = CSTS_PRE;
         CSTS_TOUT: state_d = CSTS_TOUT;
         default: state_d = CSTS_IDLE;
      endcase
      if (!en)
         state_d = CSTS_IDLE;
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_q <= CSTS_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         eoc_seen_q <= 1'b0;
      end
      else if (new_cycle || state_q == CSTS_IDLE)
      begin
         eoc_seen_q <= 1'b0;
      end
      else if (state_q == CSTS_FAST && eoc_s)
      begin
         eoc_seen_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Open-drain pins and charger control

   // Pins only ever pull low; released pins read high through pull-ups
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         status_oe_q <= 1'b0;
         fault_oe_q <= 1'b0;
      end
      else
      begin
         status_oe_q <= (state_d == CSTS_PRE) ||
                        (state_d == CSTS_FAST && !eoc_seen_q && !eoc_s);
         fault_oe_q <= (state_d == CSTS_TOUT) || (state_d == CSTS_TEMP);
      end
   end
   assign o_status_o = 1'b0;
   assign o_fault_o = 1'b0;
   assign o_status_oe = status_oe_q;
   assign o_fault_oe = fault_oe_q;
   assign o_chg_on = (state_q == CSTS_PRE) || (state_q == CSTS_FAST);
   assign o_low_power = !en_q;

   ////////////////////////////////////////////////////////////////////
   // Registers and interrupt

   assign int_ev[`CSTS_INT_TOUT_BIT] = (state_d == CSTS_TOUT) && (state_q != CSTS_TOUT);
   assign int_ev[`CSTS_INT_TEMP_BIT] = (state_d == CSTS_TEMP) && (state_q != CSTS_TEMP);
   assign int_ev[`CSTS_INT_EOC_BIT] = (state_q == CSTS_FAST) && eoc_s && !eoc_seen_q;
   assign int_ev[`CSTS_INT_DONE_BIT] = (state_d == CSTS_DONE) && (state_q != CSTS_DONE);
   assign wr_lo = reg_if.wr_en && reg_if.wr_strb[0];

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ctrl_en_q <= `CSTS_CTRL_RST;
         int_mask_q <= `CSTS_INT_MASK_RST;
         int_stat_q <= 4'h0;
      end
      else
      begin
         if (wr_lo && reg_if.wr_addr == `CSTS_OFF_CTRL)
            ctrl_en_q <= reg_if.wr_data[`CSTS_CTRL_EN_BIT];
         if (wr_lo && reg_if.wr_addr == `CSTS_OFF_INT_MASK)
            int_mask_q <= reg_if.wr_data[3:0];
         // Hardware set wins over a same-cycle clear
         if (wr_lo && reg_if.wr_addr == `CSTS_OFF_INT_STAT)
            int_stat_q <= (int_stat_q & ~reg_if.wr_data[3:0]) | int_ev;
         else
            int_stat_q <= int_stat_q | int_ev;
      end
   end
   assign o_irq = |(int_stat_q & int_mask_q);

   assign reg_if.w_hit = (reg_if.wr_addr == `CSTS_OFF_CTRL) ||
                         (reg_if.wr_addr == `CSTS_OFF_INT_STAT) ||
                         (reg_if.wr_addr == `CSTS_OFF_INT_MASK);
   always_comb
   begin
      reg_if.rd_data = 32'h0;
      reg_if.r_hit = 1'b1;
      unique case (reg_if.rd_addr)
         `CSTS_OFF_CTRL: reg_if.rd_data[0] = ctrl_en_q;
         `CSTS_OFF_STATE: reg_if.rd_data[8:0] = {pin_rb_s, en_pin_s, eoc_seen_q, hot_q,
                                                cold_q, state_q};
         `CSTS_OFF_TIMER: reg_if.rd_data[TMR_W-1:0] = cnt_q;
         `CSTS_OFF_INT_STAT: reg_if.rd_data[3:0] = int_stat_q;
         `CSTS_OFF_INT_MASK: reg_if.rd_data[3:0] = int_mask_q;
         default: reg_if.r_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_fast_expiry;
      state_q == CSTS_FAST && en && !temp_bad && full_hit;
   endsequence
   sequence s_en_toggle;
      !en ##1 en;
   endsequence

   property p_window_fault;
      s_fast_expiry and !eoc_seen_q |=> state_q == CSTS_TOUT ##1 fault_oe_q;
   endproperty
   a_window_fault: assert property (p_window_fault) else $error("expiry missed fault");

   property p_fault_held;
      state_q == CSTS_TOUT && en |=> state_q == CSTS_TOUT && !o_chg_on;
   endproperty
   a_fault_held: assert property (p_fault_held) else $error("fault not latched");

   property p_release;
      s_en_toggle |=> cnt_q == '0 && state_q == CSTS_PRE;
   endproperty
   a_release: assert property (p_release) else $error("toggle did not release");

   property p_pre_limit;
      state_q == CSTS_PRE && en && !temp_bad && pre_hit && !vbat_min_s |=> state_q == CSTS_TOUT;
   endproperty
   a_pre_limit: assert property (p_pre_limit) else $error("precharge limit missed");

   property p_temp_stop;
      o_chg_on && en && temp_bad |=> !o_chg_on ##1 fault_oe_q && !status_oe_q;
   endproperty
   a_temp_stop: assert property (p_temp_stop) else $error("hot or cold kept charging");

   property p_temp_resume;
      state_q == CSTS_TEMP && en && !temp_bad |=> state_q == CSTS_PRE && cnt_q == '0;
   endproperty
   a_temp_resume: assert property (p_temp_resume) else $error("no restart");

   property p_cold_hyst;
      $rose(cold_q) |-> $past(cmp_a_rise_s);
   endproperty
   a_cold_hyst: assert property (p_cold_hyst) else $error("cold flag cause");

   property p_hot_hyst;
      $fell(hot_q) |-> $past(cmp_b_rise_s) && !$past(cmp_b_fall_s);
   endproperty
   a_hot_hyst: assert property (p_hot_hyst) else $error("hot flag clear cause");

   property p_encoding;
      !(status_oe_q && fault_oe_q) && (!fault_oe_q || state_q inside {CSTS_TOUT, CSTS_TEMP});
   endproperty
   a_encoding: assert property (p_encoding) else $error("bad pin encoding");

   property p_disable;
      !en |=> state_q == CSTS_IDLE && !o_chg_on && o_low_power;
   endproperty
   a_disable: assert property (p_disable) else $error("enable low kept charging");

   property p_recharge;
      state_q == CSTS_DONE && en && !temp_bad && rch_s |=> state_q == CSTS_PRE;
   endproperty
   a_recharge: assert property (p_recharge) else $error("no recharge");

   property p_eoc_status;
      state_q == CSTS_FAST && eoc_seen_q && !full_hit && en && !temp_bad
         |=> o_chg_on && !status_oe_q;
   endproperty
   a_eoc_status: assert property (p_eoc_status) else $error("eoc handling");
endmodule // csts_top
`default_nettype wire

/* File: hdl/csts_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz reference clock, 3 ms oscillator period
// Notes: Definitions only
`ifndef CSTS_REGS_SVH
`define CSTS_REGS_SVH

`define CSTS_CLK_PERIOD_NS 50
`define CSTS_OSC_PERIOD_NS 3000000
`define CSTS_OSC_CYCLES (`CSTS_OSC_PERIOD_NS / `CSTS_CLK_PERIOD_NS)
`define CSTS_TMR_BITS 22
`define CSTS_PRE_SHIFT 3

`define CSTS_OFF_CTRL 8'h00
`define CSTS_OFF_STATE 8'h04
`define CSTS_OFF_TIMER 8'h08
`define CSTS_OFF_INT_STAT 8'h0c
`define CSTS_OFF_INT_MASK 8'h10

`define CSTS_CTRL_EN_BIT 0
`define CSTS_CTRL_RST 1'h1
`define CSTS_INT_MASK_RST 4'h0

`define CSTS_INT_TOUT_BIT 0
`define CSTS_INT_TEMP_BIT 1
`define CSTS_INT_EOC_BIT 2
`define CSTS_INT_DONE_BIT 3

`endif

/* File: hdl/csts_pkg.sv */
// Purpose: Types shared by the charge safety timer files
// Assumes: Nothing beyond the register header
// Notes: Gray codes along idle, precharge, fast, done
package csts_pkg;
   typedef logic [7:0] csts_addr_t;
   typedef enum logic [2:0]
   {
      CSTS_IDLE = 3'h0,
      CSTS_PRE = 3'h1,
      CSTS_FAST = 3'h3,
      CSTS_DONE = 3'h2,
      CSTS_TEMP = 3'h6,
      CSTS_TOUT = 3'h7
   } csts_state_e;
   typedef enum logic [1:0]
   {
      CSTS_OKAY = 2'h0,
      CSTS_SLVERR = 2'h2
   } csts_resp_e;
endpackage

/* File: hdl/csts_reg_if.sv */
// Purpose: Register access between bus slave and core
// Assumes: One clock domain
// Notes: Read data is combinational from the read address
`timescale 1ns/10ps
`default_nettype none
interface csts_reg_if;
   import csts_pkg::*;
   logic wr_en;
   csts_addr_t wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   csts_addr_t rd_addr;
   logic [31:0] rd_data;
   logic w_hit;
   logic r_hit;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data, w_hit, r_hit);
   modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data, w_hit, r_hit);
endinterface
`default_nettype wire

/* File: hdl/csts_sync.sv */
// Purpose: Three-stage pin synchroniser per bit
// Assumes: Inputs asynchronous to i_ref_clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module csts_sync #(
   parameter int W = 1
) (
   input wire logic i_ref_clk, // Clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic [W-1:0] i_async, // Pin levels
   output logic [W-1:0] o_sync // Filtered levels
);
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic out_q;
         always_ff @(posedge i_ref_clk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               out_q <= 1'b0;
            end
            else
            begin
               s1_q <= i_async[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
               begin
                  out_q <= s3_q;
               end
            end
         end
         assign o_sync[g] = out_q;
      end
   endgenerate
endmodule // csts_sync
`default_nettype wire

/* File: hdl/csts_axil.sv */
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: One write and one read outstanding at most
// Notes: Address and data may arrive in either order
`timescale 1ns/10ps
`default_nettype none
module csts_axil (
   input wire logic i_ref_clk, // Clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_awvalid, // Write address valid
   output logic o_awready, // Write address ready
   input wire csts_pkg::csts_addr_t i_awaddr, // Write address
   input wire logic i_wvalid, // Write data valid
   output logic o_wready, // Write data ready
   input wire logic [31:0] i_wdata, // Write data
   input wire logic [3:0] i_wstrb, // Byte strobes
   output logic o_bvalid, // Write response valid
   input wire logic i_bready, // Write response ready
   output logic [1:0] o_bresp, // Write response
   input wire logic i_arvalid, // Read address valid
   output logic o_arready, // Read address ready
   input wire csts_pkg::csts_addr_t i_araddr, // Read address
   output logic o_rvalid, // Read data valid
   input wire logic i_rready, // Read data ready
   output logic [31:0] o_rdata, // Read data
   output logic [1:0] o_rresp, // Read response
   csts_reg_if.bus reg_if // Register access
);
   import csts_pkg::*;
   logic aw_got_q;
   logic w_got_q;
   logic bvalid_q;
   logic rvalid_q;
   csts_resp_e bresp_q;
   csts_resp_e rresp_q;
   logic [31:0] rdata_q;

   assign o_awready = !aw_got_q;
   assign o_wready = !w_got_q;
   assign o_arready = !rvalid_q;
   assign o_bvalid = bvalid_q;
   assign o_rvalid = rvalid_q;
   assign o_bresp = bresp_q;
   assign o_rresp = rresp_q;
   assign o_rdata = rdata_q;
   assign reg_if.wr_en = aw_got_q && w_got_q && !bvalid_q;
   assign reg_if.rd_addr = i_araddr;

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= CSTS_OKAY;
         reg_if.wr_addr <= '0;
         reg_if.wr_data <= '0;
         reg_if.wr_strb <= '0;
      end
      else
      begin
         if (i_awvalid && !aw_got_q)
         begin
            aw_got_q <= 1'b1;
            reg_if.wr_addr <= i_awaddr;
         end
         if (i_wvalid && !w_got_q)
         begin
            w_got_q <= 1'b1;
            reg_if.wr_data <= i_wdata;
            reg_if.wr_strb <= i_wstrb;
         end
         if (reg_if.wr_en)
         begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= reg_if.w_hit ? CSTS_OKAY : CSTS_SLVERR;
         end
         else if (i_bready)
         begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rvalid_q <= 1'b0;
         rresp_q <= CSTS_OKAY;
         rdata_q <= '0;
      end
      else if (i_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= reg_if.rd_data;
         rresp_q <= reg_if.r_hit ? CSTS_OKAY : CSTS_SLVERR;
      end
      else if (i_rready)
      begin
         rvalid_q <= 1'b0;
      end
   end
endmodule // csts_axil
`default_nettype wire

/* File: sim/csts_pack_model.sv */
// Purpose: Battery pack, thermistor divider and pin pull-ups
// Assumes: Sense level given in millivolts
// Notes: Released open-drain pins read high through pull-ups
`timescale 1ns/10ps
`default_nettype none
module csts_pack_model (
   input wire logic [15:0] i_temp_mv, // Thermistor sense level
   input wire logic i_status_o, // Status drive value
   input wire logic i_status_oe, // Status pull low
   input wire logic i_fault_o, // Fault drive value
   input wire logic i_fault_oe, // Fault pull low
   output logic o_cmp_a_rise, // Above cold set level
   output logic o_cmp_a_fall, // Below cold clear level
   output logic o_cmp_b_fall, // Below hot set level
   output logic o_cmp_b_rise, // Above hot clear level
   output logic o_status_pin, // Status wire level
   output logic o_fault_pin // Fault wire level
);
   assign o_cmp_a_rise = i_temp_mv > 16'd1400;
   assign o_cmp_a_fall = i_temp_mv < 16'd1200;
   assign o_cmp_b_fall = i_temp_mv < 16'd350;
   assign o_cmp_b_rise = i_temp_mv > 16'd400;
   assign o_status_pin = i_status_oe ? i_status_o : 1'b1;
   assign o_fault_pin = i_fault_oe ? i_fault_o : 1'b1;
endmodule // csts_pack_model
`default_nettype wire

/* File: sim/charge_safety_timer_status_tb.sv */
// Purpose: Self-checking bench for the charge safety timer
// Assumes: Shortened oscillator tick and timer width
// Notes: Response ready held high throughout
`timescale 1ns/10ps
`default_nettype none
module charge_safety_timer_status_tb;
   import csts_pkg::*;
   logic i_ref_clk = 0, i_rstn = 0, i_awvalid = 0, i_wvalid = 0, i_arvalid = 0, i_en_pin = 1;
   logic i_bready = 1, i_rready = 1, i_vbat_above_min = 0, i_eoc_current = 0;
   logic i_below_recharge_threshold = 0, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_status_o, o_status_oe, o_fault_o, o_fault_oe, o_chg_on, o_low_power, o_irq;
   logic [7:0] i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata, seed = 32'd73892;
   logic [3:0] i_wstrb = 4'hf;
   logic [1:0] o_bresp, o_rresp;
   logic [15:0] mv = 16'd800;
   wire logic i_window_comparator_a_rise, i_window_comparator_a_fall, i_status_pin;
   wire logic i_window_comparator_b_fall, i_window_comparator_b_rise, i_fault_pin;
   int miscompares = 0, tests_run = 0;
   int mvs [6] = '{1500, 1300, 1000, 300, 380, 500};
   csts_state_e sts [6] = '{CSTS_TEMP, CSTS_TEMP, CSTS_FAST, CSTS_TEMP, CSTS_TEMP, CSTS_FAST};
   always #25 i_ref_clk = ~i_ref_clk;
   csts_top #(.OSC_DIV(4), .TMR_W(8), .PRE_SHIFT(3)) csts_top_i (.*);
   csts_pack_model csts_pack_model_i (.i_temp_mv(mv), .i_status_o(o_status_o),
      .i_status_oe(o_status_oe), .i_fault_o(o_fault_o), .i_fault_oe(o_fault_oe),
      .o_cmp_a_rise(i_window_comparator_a_rise), .o_cmp_a_fall(i_window_comparator_a_fall),
      .o_cmp_b_fall(i_window_comparator_b_fall), .o_cmp_b_rise(i_window_comparator_b_rise),
      .o_status_pin(i_status_pin), .o_fault_pin(i_fault_pin));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [39:0] s, input logic [39:0] e);
      tests_run++;
      if (s !== e)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task tmo(input int n);
      if (n >= 50)
      begin
         miscompares++;
         conclude();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1;
      i_wvalid <= 1;
      do
      begin
         @(posedge i_ref_clk);
         n++;
         if (o_awready) i_awvalid <= 0;
         if (o_wready) i_wvalid <= 0;
      end
      while (!o_bvalid && n < 50);
      tmo(n);
      chk(o_bresp, er);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      int n;
      n = 0;
      i_araddr <= a;
      i_arvalid <= 1;
      do
      begin
         @(posedge i_ref_clk);
         n++;
         if (o_arready) i_arvalid <= 0;
      end
      while (!o_rvalid && n < 50);
      tmo(n);
      chk({o_rresp, o_rdata & m}, {er, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge i_ref_clk);
      i_rstn <= 1;
      repeat (10) @(posedge i_ref_clk);
      rd(8'h00, 1, 1, 0);
      rd(8'h10, 0, 32'hf, 0);
      rd(8'h20, 0, '1, 2);
      rd(8'h04, CSTS_PRE, 7, 0);
      chk({i_status_pin, i_fault_pin, o_chg_on}, 3'b011);
      repeat (70) @(posedge i_ref_clk);
      rd(8'h04, CSTS_PRE, 7, 0);
      repeat (100) @(posedge i_ref_clk);
      rd(8'h04, CSTS_TOUT, 7, 0);
      chk({i_status_pin, i_fault_pin, o_chg_on}, 3'b100);
      rd(8'h0c, 1, 1, 0);
      chk(o_irq, 0);
      seed = lfsr(seed);
      wr(8'h10, seed | 1, 0);
      rd(8'h10, seed[3:0] | 1, 32'hf, 0);
      chk(o_irq, 1);
      wr(8'h0c, 1, 0);
      rd(8'h0c, 0, 1, 0);
      chk(o_irq, 0);
      wr(8'h40, 1, 2);
      rd(8'h04, CSTS_TOUT, 7, 0);
      i_en_pin <= 0;
      repeat (10) @(posedge i_ref_clk);
      chk(o_low_power, 1);
      i_vbat_above_min <= 1;
      i_en_pin <= 1;
      repeat (10) @(posedge i_ref_clk);
      rd(8'h04, CSTS_FAST, 7, 0);
      repeat (900) @(posedge i_ref_clk);
      rd(8'h04, CSTS_FAST, 7, 0);
      repeat (200) @(posedge i_ref_clk);
      rd(8'h04, CSTS_TOUT, 7, 0);
      i_en_pin <= 0;
      repeat (10) @(posedge i_ref_clk);
      i_en_pin <= 1;
      repeat (100) @(posedge i_ref_clk);
      i_eoc_current <= 1;
      repeat (20) @(posedge i_ref_clk);
      rd(8'h04, 32'h23, 32'h27, 0);
      chk(o_chg_on, 1);
      repeat (1000) @(posedge i_ref_clk);
      rd(8'h04, CSTS_DONE, 7, 0);
      chk({i_status_pin, i_fault_pin}, 2'b11);
      i_eoc_current <= 0;
      i_below_recharge_threshold <= 1;
      repeat (20) @(posedge i_ref_clk);
      rd(8'h04, CSTS_FAST, 7, 0);
      i_below_recharge_threshold <= 0;
      for (int i = 0; i < 6; i++)
      begin
         mv <= mvs[i][15:0];
         repeat (20) @(posedge i_ref_clk);
         rd(8'h04, sts[i], 7, 0);
         chk(i_fault_pin, sts[i] != CSTS_TEMP);
      end
      rd(8'h0c, 32'hf, 32'hf, 0);
      chk(o_irq, 1);
      conclude();
   end
endmodule // charge_safety_timer_status_tb
`default_nettype wire
